// file: core/three_wire_regs.svh
`ifndef THREE_WIRE_REGS_SVH
`define THREE_WIRE_REGS_SVH

// register offsets
`define MODE_OFS   16'hFF90
`define SHIFT_OFS  16'hFF91
`define STATUS_OFS 16'hFF92
`define TRIG_OFS   16'hFF93
`define END_OFS    16'hFF94
`define GAP_OFS    16'hFF95
`define DIV_OFS    16'hFF96
`define CNT_OFS    16'hFF97
`define BUF_BASE   16'hFA00

// reset values
`define MODE_RST   8'h00
`define STATUS_RST 8'h00
`define DIV_RST    8'h03

// mode register fields
`define MODE_EN     7
`define MODE_AUTO   6
`define MODE_REPEAT 5
`define MODE_MASTER 4
`define MODE_TXEN   3
`define MODE_RXEN   2
`define MODE_DIR    1
`define MODE_WMASK  8'hFE

// status register fields
`define ST_BUSY  0
`define ST_ERRE  2
`define ST_BUSYE 4
`define ST_STBE  5
`define ST_IRQ   7
`define ST_WMASK 8'h34

// trigger register fields
`define TRIG_START 0
`define TRIG_STOP  1

// timing counts in serial clocks and bits
`define MIN_GAP_STB  6'h02
`define MIN_GAP_BUSY 6'h01
`define WORD_BITS    4'h8

`endif

// file: core/three_wire_pkg.sv
package three_wire_pkg;
  typedef enum logic [4:0] {
    XFER_IDLE  = 5'b00001,
    XFER_LOAD  = 5'b00010,
    XFER_SHIFT = 5'b00100,
    XFER_STORE = 5'b01000,
    XFER_GAP   = 5'b10000
  } xferState_t;
endpackage

// file: core/sync_2ff.sv
module sync_2ff (
  input  wire logic sys_clk,  // destination clock
  input  wire logic rstn,     // async reset, active low
  input  wire logic asyncIn,  // level from another domain
  output logic      syncOut   // synchronised level
);
  logic meta_q;

  // two-stage synchroniser, first stage read only by the second
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      meta_q  <= 1'b0;
      syncOut <= 1'b0;
    end else begin
      meta_q  <= asyncIn;
      syncOut <= meta_q;
    end
  end
endmodule

// file: core/serial_shifter.sv
`include "three_wire_regs.svh"
module serial_shifter (
  input  wire logic       serialClk, // link clock from the clock pin
  input  wire logic       clrN,      // async clear, active low
  input  wire logic [7:0] txWord,    // word held stable while clear is released
  input  wire logic       serialIn,  // data-in pin level
  input  wire logic       rxEnable,  // gates received bits
  output logic            soBit,     // data-out bit
  output logic      [7:0] rxWord,    // received word
  output logic            done       // high after the eighth rising edge
);
  logic [3:0] bitCnt_q;
  logic       sample_q;

  // falling edge: present next bit and sample input
  always_ff @(negedge serialClk or negedge clrN) begin
    if (!clrN) begin
      soBit    <= 1'b0;
      sample_q <= 1'b0;
    end else if (bitCnt_q < `WORD_BITS) begin
      soBit    <= txWord[3'(4'd7 - bitCnt_q)];
      sample_q <= serialIn & rxEnable;
    end
  end

  // rising edge: store sampled bit, count bits
  always_ff @(posedge serialClk or negedge clrN) begin
    if (!clrN) begin
      rxWord   <= 8'h00;
      bitCnt_q <= 4'h0;
      done     <= 1'b0;
    end else if (bitCnt_q < `WORD_BITS) begin
      rxWord   <= {rxWord[6:0], sample_q};
      bitCnt_q <= bitCnt_q + 4'h1;
      done     <= (bitCnt_q == 4'h7);
    end
  end
endmodule

// file: core/three_wire_port.sv
// How it works
// - Reset clears mode register to zero: port off, single-byte mode.
// - Enable low stops port, data-out low, clock high, link logic reset async.
// - Auto-transfer bit 6 picks single-byte (0) or buffer automatic (1) mode.
// - Bits shift and sample on falling clock edge, stored on following rising edge.
// - After eight bits in single-byte mode, or after the last byte of an automatic run, the port stops and raises its done flag and pulse.
// - Repeat bit 5 has no effect in single-byte mode.
// - Writing the shift register holds data-out low before the first edge.
// - Word is eight bits; mode bit 1 picks MSB or LSB first.
// - Bit order is swapped on the bus path, shift direction never changes.
// - A shift write starts only when enabled and no transfer runs.
// - A write made while disabled never starts a transfer later.
// - Master drives clock from divisor; slave takes clock from the pin.
// - Transmit enable bit releases the data-out pin; receive enable bit gates bits taken from data-in.
// - Automatic mode moves up to 32 buffer bytes without software.
// - Auto master with strobe and busy enabled drives strobe, samples busy.
// - Address counter steps per byte to end address; repeat clears and restarts.
// - In master mode gap is at least two clocks with strobe, one with busy only.
`include "three_wire_regs.svh"
module three_wire_port
  import three_wire_pkg::*;
#(
  parameter int BUF_DEPTH = 32,  // buffer bytes
  parameter int ADDR_W    = 5    // buffer index width
) (
  input  wire logic        sys_clk,        // system clock
  input  wire logic        rstn,           // async reset, active low
  input  wire logic        clkEn,          // freezes state while low
  input  wire logic [15:0] cpuAddr,        // register address
  input  wire logic        cpuWr,          // write strobe
  input  wire logic        cpuRd,          // read strobe
  input  wire logic [7:0]  cpuWdata,       // write data
  output logic      [7:0]  cpuRdata,       // read data, one cycle after strobe
  input  wire logic        serialClkIn,    // clock pin level, link clock
  output logic             serialClkOut,   // clock pin drive
  output logic             serialClkOe,    // clock pin enable
  output logic             serialOut,      // data-out pin drive
  output logic             serialOutOe,    // data-out pin enable
  input  wire logic        serialIn,       // data-in pin
  output logic             strobeOut,      // strobe pin drive
  output logic             strobeOe,       // strobe pin enable
  input  wire logic        busyIn,         // busy pin
  output logic             transferDoneIrq // one-cycle done pulse
);
  xferState_t         state_q;
  logic [7:0]         modeCtl_q, statusCfg_q, shift_q, div_q, halfCnt_q, gapCnt_q;
  logic [ADDR_W-1:0]  endAddr_q, addrCnt_q;
  logic [5:0]         gap_q, minGap, gapTarget;
  logic [7:0]         mem_q [BUF_DEPTH];
  logic [7:0]         rxWord;
  logic [3:0]         riseCnt_q;
  logic               irqFlag_q, armed_q, sck_q, strobe_q, stopReq_q;
  logic               doneSync, busySync, linkClrN, soBit, tick, gapDone, armedDone;
  logic               portEn, autoMode, master, handshake, busIdle;
  logic               wrMode, wrShift, wrStatus, wrTrig, bufSel;
  logic               startSingle, startAuto, lastByte;

  function automatic logic [7:0] rev8(input logic [7:0] v);
    return {v[0], v[1], v[2], v[3], v[4], v[5], v[6], v[7]};
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // decode
  assign portEn    = modeCtl_q[`MODE_EN];
  assign autoMode  = modeCtl_q[`MODE_AUTO];
  assign master    = modeCtl_q[`MODE_MASTER];
  assign handshake = autoMode & master & statusCfg_q[`ST_STBE]
                   & statusCfg_q[`ST_BUSYE];
  assign busIdle   = (state_q == XFER_IDLE);
  assign wrMode    = cpuWr && (cpuAddr == `MODE_OFS);
  assign wrShift   = cpuWr && (cpuAddr == `SHIFT_OFS);
  assign wrStatus  = cpuWr && (cpuAddr == `STATUS_OFS);
  assign wrTrig    = cpuWr && (cpuAddr == `TRIG_OFS);
  assign bufSel    = (cpuAddr[15:ADDR_W] == `BUF_BASE >> ADDR_W);
  // a write while disabled or busy starts nothing
  assign startSingle = wrShift && portEn && busIdle && !autoMode;
  assign startAuto   = wrTrig && cpuWdata[`TRIG_START] && portEn
                     && busIdle && autoMode;
  assign lastByte    = (addrCnt_q == endAddr_q);

  ////////////////////////////////////////////////////////////////////////////
  // synchronisers and link side
  sync_2ff u_doneSync (
    .sys_clk (sys_clk),
    .rstn    (rstn),
    .asyncIn (armedDone),
    .syncOut (doneSync)
  );

  sync_2ff u_busySync (
    .sys_clk (sys_clk),
    .rstn    (rstn),
    .asyncIn (busyIn),
    .syncOut (busySync)
  );

  // link logic is held in clear while idle or disabled
  assign linkClrN = rstn & portEn & armed_q;

  serial_shifter u_shifter (
    .serialClk (serialClkIn),
    .clrN      (linkClrN),
    .txWord    (shift_q),
    .serialIn  (serialIn),
    .rxEnable  (modeCtl_q[`MODE_RXEN]),
    .soBit     (soBit),
    .rxWord    (rxWord),
    .done      (armedDone)
  );

  ////////////////////////////////////////////////////////////////////////////
  // pins
  assign serialOut    = portEn & soBit;
  assign serialOutOe  = portEn & modeCtl_q[`MODE_TXEN];
  assign serialClkOut = sck_q;
  assign serialClkOe  = portEn & master;
  assign strobeOut    = strobe_q;
  assign strobeOe     = portEn & handshake;

  ////////////////////////////////////////////////////////////////////////////
  // mode, status, end, gap, divisor registers
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      modeCtl_q   <= `MODE_RST;
      statusCfg_q <= `STATUS_RST;
      endAddr_q   <= '0;
      gap_q       <= 6'h00;
      div_q       <= `DIV_RST;
    end else if (clkEn) begin
      if (wrMode) modeCtl_q <= cpuWdata & `MODE_WMASK;
      if (wrStatus) statusCfg_q <= cpuWdata & `ST_WMASK;
      if (cpuWr && cpuAddr == `END_OFS) endAddr_q <= cpuWdata[ADDR_W-1:0];
      if (cpuWr && cpuAddr == `GAP_OFS) gap_q <= cpuWdata[5:0];
      if (cpuWr && cpuAddr == `DIV_OFS) div_q <= cpuWdata;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // transfer sequencer
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      state_q <= XFER_IDLE;
      armed_q <= 1'b0;
    end else if (clkEn) begin
      if (!portEn) begin
        state_q <= XFER_IDLE;
        armed_q <= 1'b0;
      end else begin
        unique case (state_q)
          XFER_IDLE: if (startSingle || startAuto) state_q <= XFER_LOAD;
          XFER_LOAD: if (!doneSync) begin
            armed_q <= 1'b1;
            state_q <= XFER_SHIFT;
          end
          XFER_SHIFT: if (doneSync) begin
            armed_q <= 1'b0;
            state_q <= XFER_STORE;
          end
          XFER_STORE: begin
            // repeat bit only matters in automatic mode
            if (!autoMode) state_q <= XFER_IDLE;
            else if (stopReq_q || (lastByte && !modeCtl_q[`MODE_REPEAT]))
              state_q <= XFER_IDLE;
            else state_q <= XFER_GAP;
          end
          XFER_GAP: if (gapDone) state_q <= XFER_LOAD;
          default: state_q <= XFER_IDLE;
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // shift register: bus path reversed by bit order, shift order fixed
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      shift_q <= 8'h00;
    end else if (clkEn) begin
      if (wrShift && busIdle)
        shift_q <= modeCtl_q[`MODE_DIR] ? rev8(cpuWdata) : cpuWdata;
      else if (state_q == XFER_LOAD && autoMode)
        shift_q <= modeCtl_q[`MODE_DIR] ? rev8(mem_q[addrCnt_q])
                                        : mem_q[addrCnt_q];
      else if (state_q == XFER_SHIFT && doneSync)
        shift_q <= rxWord;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // buffer address counter and stop request
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      addrCnt_q <= '0;
      stopReq_q <= 1'b0;
    end else if (clkEn) begin
      if (startAuto) begin
        addrCnt_q <= '0;
        stopReq_q <= 1'b0;
      end else if (state_q == XFER_STORE && autoMode) begin
        if (lastByte) addrCnt_q <= modeCtl_q[`MODE_REPEAT] ? '0 : addrCnt_q;
        else addrCnt_q <= addrCnt_q + 1'b1;
      end
      if (wrTrig && cpuWdata[`TRIG_STOP] && !busIdle) stopReq_q <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // buffer storage, one entry per generate step
  genvar gi;
  generate
    for (gi = 0; gi < BUF_DEPTH; gi++) begin : g_buf
      always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
          mem_q[gi] <= 8'h00;
        end else if (clkEn) begin
          if (state_q == XFER_STORE && autoMode && modeCtl_q[`MODE_RXEN]
              && addrCnt_q == ADDR_W'(gi))
            mem_q[gi] <= modeCtl_q[`MODE_DIR] ? rev8(shift_q) : shift_q;
          else if (cpuWr && bufSel && cpuAddr[ADDR_W-1:0] == ADDR_W'(gi))
            mem_q[gi] <= cpuWdata;
        end
      end
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // master clock divider and byte gap
  assign tick      = (halfCnt_q == div_q);
  assign minGap    = statusCfg_q[`ST_STBE] ? `MIN_GAP_STB :
                     statusCfg_q[`ST_BUSYE] ? `MIN_GAP_BUSY : 6'h00;
  assign gapTarget = !master ? 6'h00 : (gap_q > minGap) ? gap_q : minGap;
  assign gapDone   = (gapCnt_q >= {1'b0, gapTarget, 1'b0}) && !(handshake && busySync);

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      halfCnt_q <= 8'h00;
    end else if (clkEn) begin
      if ((state_q == XFER_SHIFT || state_q == XFER_GAP) && master && !tick)
        halfCnt_q <= halfCnt_q + 8'h01;
      else
        halfCnt_q <= 8'h00;
    end
  end

  // clock idles high; eight low/high periods per byte
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      sck_q     <= 1'b1;
      riseCnt_q <= 4'h0;
    end else if (clkEn) begin
      if (!portEn || state_q != XFER_SHIFT || !master) begin
        sck_q     <= 1'b1;
        riseCnt_q <= 4'h0;
      end else if (tick) begin
        if (sck_q && riseCnt_q < `WORD_BITS) begin
          sck_q <= 1'b0;
        end else if (!sck_q) begin
          sck_q     <= 1'b1;
          riseCnt_q <= riseCnt_q + 4'h1;
        end
      end
    end
  end

  // gap half-periods and strobe during the first gap clock
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      gapCnt_q <= 8'h00;
      strobe_q <= 1'b0;
    end else if (clkEn) begin
      if (state_q != XFER_GAP) begin
        gapCnt_q <= 8'h00;
        strobe_q <= 1'b0;
      end else begin
        if (tick && gapCnt_q != 8'hFF) gapCnt_q <= gapCnt_q + 8'h01;
        strobe_q <= handshake && (gapCnt_q < 8'h02);
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // done flag and pulse; a new event wins over a software clear
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      irqFlag_q       <= 1'b0;
      transferDoneIrq <= 1'b0;
    end else if (clkEn) begin
      transferDoneIrq <= 1'b0;
      if (!portEn) begin
        irqFlag_q <= 1'b0;
      end else if (state_q == XFER_STORE
                   && (!autoMode || stopReq_q || (lastByte && !modeCtl_q[`MODE_REPEAT]))) begin
        irqFlag_q       <= 1'b1;
        transferDoneIrq <= 1'b1;
      end else if (wrStatus && !cpuWdata[`ST_IRQ]) begin
        irqFlag_q <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // registered read port
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      cpuRdata <= 8'h00;
    end else if (clkEn && cpuRd) begin
      if (bufSel) cpuRdata <= mem_q[cpuAddr[ADDR_W-1:0]];
      else begin
        unique case (cpuAddr)
          `MODE_OFS:   cpuRdata <= modeCtl_q;
          `SHIFT_OFS:  cpuRdata <= modeCtl_q[`MODE_DIR] ? rev8(shift_q) : shift_q;
          `STATUS_OFS: cpuRdata <= {irqFlag_q, statusCfg_q[6:1], !busIdle};
          `END_OFS:    cpuRdata <= 8'(endAddr_q);
          `GAP_OFS:    cpuRdata <= {2'b00, gap_q};
          `DIV_OFS:    cpuRdata <= div_q;
          `CNT_OFS:    cpuRdata <= 8'(addrCnt_q);
          default:     cpuRdata <= 8'h00;
        endcase
      end
    end
  end
endmodule

// file: verification/three_wire_port_properties.sv
`include "three_wire_regs.svh"
module three_wire_port_properties #(
  parameter int BUF_DEPTH = 32,  // buffer bytes
  parameter int ADDR_W    = 5    // buffer index width
) (
  input wire logic        sys_clk,        // system clock
  input wire logic        rstn,           // async reset, active low
  input wire logic        clkEn,          // state freeze
  input wire logic [15:0] cpuAddr,        // register address
  input wire logic        cpuWr,          // write strobe
  input wire logic        cpuRd,          // read strobe
  input wire logic [7:0]  cpuWdata,       // write data
  input wire logic [7:0]  cpuRdata,       // read data
  input wire logic        serialClkIn,    // clock pin level
  input wire logic        serialClkOut,   // clock pin drive
  input wire logic        serialClkOe,    // clock pin enable
  input wire logic        serialOut,      // data-out drive
  input wire logic        serialOutOe,    // data-out enable
  input wire logic        serialIn,       // data-in pin
  input wire logic        strobeOut,      // strobe drive
  input wire logic        strobeOe,       // strobe enable
  input wire logic        busyIn,         // busy pin
  input wire logic        transferDoneIrq // done pulse
);
  logic [7:0] modeQ;   // mode register shadow
  logic       stbEnQ;  // strobe enable shadow
  logic       bsyEnQ;  // busy enable shadow
  logic [7:0] divQ;    // divisor shadow
  logic       clkPrevQ; // clock drive one cycle ago
  logic [3:0] fallCnt; // falling clock edges since a shift write
  logic [8:0] lowCnt;  // cycles the clock has been low
  logic       wrShift; // accepted shift write

  assign wrShift = clkEn && cpuWr && cpuAddr == `SHIFT_OFS;

  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rstn);

  // register shadows follow accepted writes
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      modeQ  <= `MODE_RST;
      stbEnQ <= 1'b0;
      bsyEnQ <= 1'b0;
      divQ   <= `DIV_RST;
    end else if (clkEn && cpuWr) begin
      if (cpuAddr == `MODE_OFS) modeQ <= cpuWdata & `MODE_WMASK;
      if (cpuAddr == `STATUS_OFS) stbEnQ <= cpuWdata[`ST_STBE];
      if (cpuAddr == `STATUS_OFS) bsyEnQ <= cpuWdata[`ST_BUSYE];
      if (cpuAddr == `DIV_OFS) divQ <= cpuWdata;
    end
  end

  // edge and low-time counters on the driven clock
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      clkPrevQ <= 1'b1;
      fallCnt  <= 4'h0;
      lowCnt   <= 9'h000;
    end else begin
      clkPrevQ <= serialClkOut;
      if (wrShift) fallCnt <= 4'h0;
      else if (clkPrevQ && !serialClkOut && fallCnt != 4'hF) fallCnt <= fallCnt + 4'h1;
      lowCnt <= serialClkOut ? 9'h000 : lowCnt + 9'h001;
    end
  end

  a_release_idle: assert property ($rose(rstn) |-> serialClkOut && !serialClkOe
    && !serialOut && !serialOutOe && !strobeOe && !transferDoneIrq) else $error("pins not idle after reset");
  a_off_idle: assert property ((!modeQ[`MODE_EN])[*2] |-> serialClkOut && !serialOut
    && !serialOutOe) else $error("disabled port not idle");
  a_clock_source: assert property ($stable(modeQ) |->
    serialClkOe == (modeQ[`MODE_EN] && modeQ[`MODE_MASTER])) else $error("clock enable wrong");
  a_out_release: assert property ($stable(modeQ) |->
    serialOutOe == (modeQ[`MODE_EN] && modeQ[`MODE_TXEN])) else $error("data-out enable wrong");
  a_strobe_pins: assert property ($stable({modeQ, stbEnQ, bsyEnQ}) |-> strobeOe ==
    (&{modeQ[`MODE_EN], modeQ[`MODE_AUTO], modeQ[`MODE_MASTER], stbEnQ, bsyEnQ}))
    else $error("strobe enable wrong");
  a_write_low: assert property (wrShift && modeQ[`MODE_EN] |=> !serialOut)
    else $error("data-out not low after write");
  a_eight_edges: assert property (transferDoneIrq && !modeQ[`MODE_AUTO] && modeQ[`MODE_MASTER]
    |-> fallCnt == 4'h8) else $error("byte not eight clocks");
  a_irq_pulse: assert property (transferDoneIrq |=> !transferDoneIrq)
    else $error("done pulse too long");
  a_half_period: assert property ($rose(serialClkOut) && $stable(modeQ) && modeQ[`MODE_MASTER]
    |-> lowCnt == {1'b0, divQ} + 9'h001) else $error("clock low time wrong");
endmodule

bind three_wire_port three_wire_port_properties #(.BUF_DEPTH(BUF_DEPTH), .ADDR_W(ADDR_W))
  three_wire_port_properties_inst (.sys_clk(sys_clk), .rstn(rstn), .clkEn(clkEn),
  .cpuAddr(cpuAddr), .cpuWr(cpuWr), .cpuRd(cpuRd), .cpuWdata(cpuWdata), .cpuRdata(cpuRdata),
  .serialClkIn(serialClkIn), .serialClkOut(serialClkOut), .serialClkOe(serialClkOe),
  .serialOut(serialOut), .serialOutOe(serialOutOe), .serialIn(serialIn),
  .strobeOut(strobeOut), .strobeOe(strobeOe), .busyIn(busyIn),
  .transferDoneIrq(transferDoneIrq));

// file: verification/serial_peer_model.sv
module serial_peer_model (
  input  wire logic       clkPin,   // resolved clock pin
  input  wire logic       dataPin,  // device data-out
  input  wire logic       arm,      // frame position held clear while low
  input  wire logic       slaveGo,  // rising edge sends eight clocks
  input  wire logic [7:0] reply,    // byte returned each frame
  output logic            peerClk,  // clock driven in slave mode
  output logic            peerData, // data toward the device
  output logic      [7:0] rxByte    // last eight bits taken in
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [2:0] bitCnt; // bit position in frame

  initial begin
    peerClk = 1'b1;
    bitCnt = 3'h0;
    peerData = 1'b0;
    rxByte = 8'h00;
  end

  // first bit stands before the first falling edge
  always @(posedge arm) peerData <= reply[7];

  // take device bit on rising edge, then present the next bit for the falling edge
  always @(posedge clkPin or negedge arm) begin
    if (!arm) begin
      bitCnt <= 3'h0;
    end else begin
      rxByte <= {rxByte[6:0], dataPin};
      bitCnt <= bitCnt + 3'h1;
      // after the frame the line turns to the next first bit, reply[7] as in this frame
      peerData <= (bitCnt == 3'h7) ? reply[7] : reply[3'h6 - bitCnt];
    end
  end

  // eight link clock periods, clock stands high outside the frame
  always @(posedge slaveGo) begin
    repeat (8) begin
      #16 peerClk = 1'b0;
      #16 peerClk = 1'b1;
    end
  end
endmodule

// file: verification/three_wire_port_test.sv
`include "three_wire_regs.svh"
module three_wire_port_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic sys_clk, rstn, clkEn, cpuWr, cpuRd, busyIn, arm, slaveGo;
  logic [15:0] cpuAddr;
  logic [7:0]  cpuWdata, cpuRdata, reply, rxByte, rdData;
  logic serialClkOut, serialClkOe, serialOut, serialOutOe, serialIn;
  logic strobeOut, strobeOe, transferDoneIrq, peerClk;
  wire  serialClkIn;
  int   num_errors, num_checks, irqCount, stbCount;

  assign serialClkIn = serialClkOe ? serialClkOut : peerClk;  // clock pin level
  always #10 sys_clk = ~sys_clk;
  always @(posedge sys_clk) if (transferDoneIrq === 1'b1) irqCount++;
  // strobe pulses seen on the pin, one per byte gap
  always @(posedge strobeOut) stbCount++;

  three_wire_port #(.BUF_DEPTH(32), .ADDR_W(5)) three_wire_port_inst (.sys_clk(sys_clk),
    .rstn(rstn), .clkEn(clkEn), .cpuAddr(cpuAddr), .cpuWr(cpuWr), .cpuRd(cpuRd),
    .cpuWdata(cpuWdata), .cpuRdata(cpuRdata), .serialClkIn(serialClkIn),
    .serialClkOut(serialClkOut), .serialClkOe(serialClkOe), .serialOut(serialOut),
    .serialOutOe(serialOutOe), .serialIn(serialIn), .strobeOut(strobeOut),
    .strobeOe(strobeOe), .busyIn(busyIn), .transferDoneIrq(transferDoneIrq));
  serial_peer_model serial_peer_model_inst (.clkPin(serialClkIn), .dataPin(serialOut),
    .arm(arm), .slaveGo(slaveGo), .reply(reply), .peerClk(peerClk), .peerData(serialIn),
    .rxByte(rxByte));

  task complete_run;
    begin
      $display("checks %0d errors %0d", num_checks, num_errors);
      if (num_errors == 0 && num_checks > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
    end
  endtask

  task chk(input logic [7:0] got, input logic [7:0] exp);
    begin
      num_checks++;
      if (got !== exp) begin
        num_errors++;
        $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
      end
    end
  endtask

  // one-cycle register bus write and read
  task wr(input logic [15:0] a, input logic [7:0] d);
    begin
      @(posedge sys_clk);
      cpuWr <= 1'b1;
      cpuAddr <= a;
      cpuWdata <= d;
      @(posedge sys_clk);
      cpuWr <= 1'b0;
    end
  endtask

  task rd(input logic [15:0] a, output logic [7:0] d);
    begin
      @(posedge sys_clk);
      cpuRd <= 1'b1;
      cpuAddr <= a;
      @(posedge sys_clk);
      cpuRd <= 1'b0;
      #1 d = cpuRdata;
    end
  endtask

  task wait_done;
    int i;
    begin
      for (i = 0; i < 5000; i++) begin
        @(posedge sys_clk);
        #1;
        if (transferDoneIrq === 1'b1) break;
      end
      if (i == 5000) chk(8'h00, 8'h01);
    end
  endtask

  // single byte: mode, sent byte, byte seen by peer, byte read back
  task byte_xfer(input logic [7:0] m, tx, expPeer, expRd);
    int n;
    begin
      n = irqCount;
      arm <= 1'b0;
      wr(`MODE_OFS, m);
      arm <= 1'b1;
      wr(`SHIFT_OFS, tx);
      rd(`STATUS_OFS, rdData);
      chk(rdData & 8'h01, 8'h01);
      if (!m[`MODE_MASTER]) slaveGo <= 1'b1;
      wait_done;
      slaveGo <= 1'b0;
      repeat (100) @(posedge sys_clk);
      chk(irqCount[7:0], n[7:0] + 8'h01);
      chk(rxByte, expPeer);
      rd(`STATUS_OFS, rdData);
      chk(rdData & 8'h01, 8'h00);
      rd(`SHIFT_OFS, rdData);
      chk(rdData, expRd);
    end
  endtask

  initial begin
    #1_000_000;
    num_errors++;
    $display("watchdog expired");
    complete_run;
  end

  initial begin
    sys_clk = 1'b0;
    rstn = 1'b0;
    clkEn = 1'b1;
    cpuWr = 1'b0;
    cpuRd = 1'b0;
    cpuAddr = 16'h0000;
    cpuWdata = 8'h00;
    busyIn = 1'b0;
    arm = 1'b0;
    slaveGo = 1'b0;
    reply = 8'hB4;
    repeat (4) @(posedge sys_clk);
    rstn <= 1'b1;
    rd(`MODE_OFS, rdData);
    chk(rdData, 8'h00);
    rd(`DIV_OFS, rdData);
    chk(rdData, `DIV_RST);
    rd(16'hFF9F, rdData);
    chk(rdData, 8'h00);
    byte_xfer(8'h9C, 8'hA5, 8'hA5, 8'hB4);
    byte_xfer(8'hBE, 8'h01, 8'h80, 8'h2D);
    byte_xfer(8'h8C, 8'h5A, 8'h5A, 8'hB4);
    // write while disabled must not start once enabled
    wr(`MODE_OFS, 8'h1C);
    wr(`SHIFT_OFS, 8'hFF);
    wr(`MODE_OFS, 8'h9C);
    repeat (200) @(posedge sys_clk);
    rd(`STATUS_OFS, rdData);
    chk(rdData & 8'h01, 8'h00);
    // automatic run of three bytes with strobe and busy handshake
    wr(`BUF_BASE, 8'h11);
    wr(`BUF_BASE + 16'h0001, 8'h22);
    wr(`BUF_BASE + 16'h0002, 8'h33);
    wr(`END_OFS, 8'h02);
    wr(`GAP_OFS, 8'h00);
    wr(`STATUS_OFS, 8'h30);
    arm <= 1'b0;
    wr(`MODE_OFS, 8'hDC);
    arm <= 1'b1;
    wr(`TRIG_OFS, 8'h01);
    chk({7'h00, strobeOe}, 8'h01);
    fork
      begin
        wait (strobeOut === 1'b1);
        @(posedge sys_clk) busyIn <= 1'b1;
        repeat (40) @(posedge sys_clk);
        busyIn <= 1'b0;
      end
    join_none
    wait_done;
    chk(rxByte, 8'h33);
    chk(stbCount[7:0], 8'h02);
    rd(`CNT_OFS, rdData);
    chk(rdData, 8'h02);
    for (int k = 0; k < 3; k++) begin
      rd(`BUF_BASE + 16'(k), rdData);
      chk(rdData, 8'hB4);
    end
    rd(`STATUS_OFS, rdData);
    chk(rdData & 8'h01, 8'h00);
    complete_run;
  end
endmodule
